// >>> src/evmc_pkg.sv
package evmc_pkg;

    // ==========================================================
    // register map, byte addresses
    localparam logic [11:0] EVMC_OFS_EGRESS_VEC = 12'h328;
    localparam logic [11:0] EVMC_OFS_MC_HEADER = 12'h330;
    localparam logic [11:0] EVMC_OFS_MC_CAP = 12'h334;
    localparam logic [11:0] EVMC_OFS_EGRESS_CTL = 12'h3F0;

    // ==========================================================
    // field layout
    localparam int EVMC_VEC_W = 16;
    localparam int EVMC_PORT_W = 4;
    localparam int EVMC_HDR_ID_LSB = 0;
    localparam int EVMC_HDR_VER_LSB = 16;
    localparam int EVMC_HDR_NXT_LSB = 20;
    localparam int EVMC_NXT_W = 12;
    localparam int EVMC_GRP_W = 6;
    localparam int EVMC_ECRC_BIT = 15;
    localparam int EVMC_CTL_EN_BIT = 0;
    localparam int EVMC_CTL_LOCK_BIT = 1;

    // ==========================================================
    // fixed and reset values
    localparam logic [15:0] EVMC_CAP_ID = 16'h0012;
    localparam logic [3:0] EVMC_CAP_VER = 4'h1;
    localparam logic [11:0] EVMC_NXT_RST = 12'h000;
    localparam logic [15:0] EVMC_VEC_RST = 16'h0000;
    localparam logic [5:0] EVMC_GRP_RST = 6'h1F;
    localparam logic EVMC_ECRC_RST = 1'b1;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic sel;
        logic enable;
        logic write;
        logic [11:0] addr;
        logic [31:0] wdata;
        logic [3:0] strb;
    } evmc_apb_req_s;

    typedef struct packed {
        logic [15:0] vec;
        logic [11:0] nxt_ptr;
        logic [5:0] max_grp;
        logic ecrc;
        logic egress_en;
        logic lock;
        logic ready;
        logic slverr;
        logic [31:0] rdata;
        logic [15:0] eff_vec;
        logic [6:0] grp_count;
        logic block_hit;
    } evmc_state_s;

endpackage : evmc_pkg

// >>> src/evmc_regs.sv
// Implementation choice: the APB register port.
`timescale 1ns/100ps

module evmc_regs
    import evmc_pkg::*;
#(
    parameter logic [11:0] NXT_PTR_DEFAULT = EVMC_NXT_RST
) (
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    input wire logic CORE_CE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic PREADY,
    output logic [31:0] PRDATA,
    output logic PSLVERR,
    input wire logic [EVMC_PORT_W-1:0] PORT_NUM,
    input wire logic MERGED_MODE,
    input wire logic [EVMC_PORT_W-1:0] TARGET_PORT,
    output logic [EVMC_VEC_W-1:0] EGRESS_BLOCK_BITS,
    output logic BLOCK_HIT,
    output logic [6:0] MC_GROUP_COUNT,
    output logic ECRC_REGEN_SUPPORTED,
    output logic [EVMC_NXT_W-1:0] NEXT_CAPABILITY_POINTER
);

    // ==========================================================
    // state
    localparam evmc_state_s STATE_RST = '{
        vec: EVMC_VEC_RST,
        nxt_ptr: EVMC_NXT_RST,
        max_grp: EVMC_GRP_RST,
        ecrc: EVMC_ECRC_RST,
        egress_en: 1'b0,
        lock: 1'b0,
        ready: 1'b0,
        slverr: 1'b0,
        rdata: 32'h0000_0000,
        eff_vec: 16'h0000,
        grp_count: 7'h20,
        block_hit: 1'b0
    };

    evmc_state_s state_r;
    evmc_state_s state_nxt;
    evmc_apb_req_s req;
    logic [EVMC_VEC_W-1:0] ro_mask;
    logic [31:0] wmask;
    logic [31:0] rd_word;
    logic mapped;
    logic nxt_seeded_r;

    assign req = '{sel: PSEL, enable: PENABLE, write: PWRITE, addr: PADDR, wdata: PWDATA, strb: PSTRB};

    // ==========================================================
    // hardwired vector bits
    always_comb begin
        ro_mask = '0;
        ro_mask[PORT_NUM] = 1'b1;
        if (MERGED_MODE) begin
            ro_mask[{PORT_NUM[EVMC_PORT_W-1:1], 1'b0}] = 1'b1;
            ro_mask[{PORT_NUM[EVMC_PORT_W-1:1], 1'b1}] = 1'b1;
        end
    end

    // ==========================================================
    // byte lanes
    for (genvar b = 0; b < 4; b++) begin : g_lane
        assign wmask[b*8 +: 8] = {8{req.strb[b]}};
    end

    // ==========================================================
    // read decode, reserved bits zero
    always_comb begin
        rd_word = 32'h0000_0000;
        mapped = 1'b1;
        unique case (req.addr)
            EVMC_OFS_EGRESS_VEC: begin
                rd_word[EVMC_VEC_W-1:0] = state_r.vec & ~ro_mask;
            end
            EVMC_OFS_MC_HEADER: begin
                rd_word[EVMC_HDR_ID_LSB +: 16] = EVMC_CAP_ID;
                rd_word[EVMC_HDR_VER_LSB +: 4] = EVMC_CAP_VER;
                rd_word[EVMC_HDR_NXT_LSB +: EVMC_NXT_W] = state_r.nxt_ptr;
            end
            EVMC_OFS_MC_CAP: begin
                rd_word[EVMC_GRP_W-1:0] = state_r.max_grp;
                rd_word[EVMC_ECRC_BIT] = state_r.ecrc;
            end
            EVMC_OFS_EGRESS_CTL: begin
                rd_word[EVMC_CTL_EN_BIT] = state_r.egress_en;
                rd_word[EVMC_CTL_LOCK_BIT] = state_r.lock;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // next state
    always_comb begin
        state_nxt = state_r;
        if (req.sel && req.enable && !state_r.ready) begin
            // one wait state so read data come from a flip-flop
            state_nxt.ready = 1'b1;
            state_nxt.slverr = !mapped;
            state_nxt.rdata = req.write ? 32'h0000_0000 : rd_word;
        end else if (req.sel && req.enable && state_r.ready) begin
            state_nxt.ready = 1'b0;
            state_nxt.slverr = 1'b0;
            if (req.write && mapped) begin
                unique case (req.addr)
                    EVMC_OFS_EGRESS_VEC: begin
                        // hardwired bits never store
                        state_nxt.vec = ((state_r.vec & ~wmask[15:0]) | (req.wdata[15:0] & wmask[15:0]))
                            & ~ro_mask;
                    end
                    EVMC_OFS_MC_HEADER: begin
                        if (!state_r.lock && req.strb[2] && req.strb[3]) begin
                            state_nxt.nxt_ptr = req.wdata[EVMC_HDR_NXT_LSB +: EVMC_NXT_W];
                        end
                    end
                    EVMC_OFS_MC_CAP: begin
                        if (!state_r.lock) begin
                            if (req.strb[0]) begin
                                state_nxt.max_grp = req.wdata[EVMC_GRP_W-1:0];
                            end
                            if (req.strb[1]) begin
                                state_nxt.ecrc = req.wdata[EVMC_ECRC_BIT];
                            end
                        end
                    end
                    EVMC_OFS_EGRESS_CTL: begin
                        if (req.strb[0]) begin
                            state_nxt.egress_en = req.wdata[EVMC_CTL_EN_BIT];
                            // lock is sticky until reset
                            state_nxt.lock = state_r.lock | req.wdata[EVMC_CTL_LOCK_BIT];
                        end
                    end
                    default: begin
                        state_nxt.lock = state_r.lock;
                    end
                endcase
            end
        end else begin
            state_nxt.ready = 1'b0;
            state_nxt.slverr = 1'b0;
        end
        // a mode change may hardwire bits already stored
        state_nxt.vec = state_nxt.vec & ~ro_mask;
        state_nxt.eff_vec = state_r.egress_en ? (state_r.vec & ~ro_mask) : '0;
        state_nxt.block_hit = state_nxt.eff_vec[TARGET_PORT];
        state_nxt.grp_count = {1'b0, state_r.max_grp} + 7'h01;
        if (!nxt_seeded_r) begin
            state_nxt.nxt_ptr = NXT_PTR_DEFAULT;
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_r <= STATE_RST;
            nxt_seeded_r <= 1'b0;
        end else if (CORE_CE) begin
            state_r <= state_nxt;
            nxt_seeded_r <= 1'b1;
        end
    end

    // ==========================================================
    // outputs
    assign PREADY = state_r.ready;
    assign PRDATA = state_r.rdata;
    assign PSLVERR = state_r.slverr;
    assign EGRESS_BLOCK_BITS = state_r.eff_vec;
    assign BLOCK_HIT = state_r.block_hit;
    assign MC_GROUP_COUNT = state_r.grp_count;
    assign ECRC_REGEN_SUPPORTED = state_r.ecrc;
    assign NEXT_CAPABILITY_POINTER = state_r.nxt_ptr;

endmodule : evmc_regs

// >>> tb/evmc_regs_assertions.sv
`timescale 1ns/100ps
// ====
// checker
module evmc_regs_chk
    import evmc_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic PREADY,
    input wire logic [31:0] PRDATA,
    input wire logic [3:0] TARGET_PORT,
    input wire logic [15:0] EGRESS_BLOCK_BITS,
    input wire logic BLOCK_HIT,
    input wire logic [6:0] MC_GROUP_COUNT,
    input wire logic ECRC_REGEN_SUPPORTED,
    input wire logic [11:0] NEXT_CAPABILITY_POINTER
);
    logic [3:0] tp_r;
    wire logic rd_h = PREADY && PSEL && !PWRITE && PADDR == EVMC_OFS_MC_HEADER;
    wire logic rd_c = PREADY && PSEL && !PWRITE && PADDR == EVMC_OFS_MC_CAP;
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RESET_N);
    // hit moves with the bits but indexes by the target seen one edge earlier
    always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) tp_r <= 4'h0;
        else tp_r <= TARGET_PORT;
    end
    a_ready_wait: assert property ($rose(PENABLE) && PSEL |-> !PREADY ##1 PREADY)
        else $error("pready not after one wait");
    a_ready_pulse: assert property (PREADY |=> !PREADY)
        else $error("pready too long");
    a_hdr_id: assert property (rd_h |-> PRDATA[15:0] == EVMC_CAP_ID)
        else $error("bad capability id");
    a_hdr_ver: assert property (rd_h |-> PRDATA[19:16] == EVMC_CAP_VER)
        else $error("bad capability version");
    a_nxt_ptr: assert property (rd_h |-> PRDATA[31:20] == NEXT_CAPABILITY_POINTER)
        else $error("pointer mismatch");
    a_cap_fixed: assert property (rd_c |-> {PRDATA[31:16], PRDATA[14:6]} == 25'h0)
        else $error("reserved bits set");
    a_ecrc_read: assert property (rd_c |-> PRDATA[15] == ECRC_REGEN_SUPPORTED)
        else $error("ecrc mismatch");
    a_grp_count: assert property (rd_c |-> MC_GROUP_COUNT == {1'b0, PRDATA[5:0]} + 7'h01)
        else $error("group count mismatch");
    a_block_hit: assert property (BLOCK_HIT == EGRESS_BLOCK_BITS[tp_r])
        else $error("block hit mismatch");
endmodule : evmc_regs_chk

bind evmc_regs evmc_regs_chk u_chk (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PREADY(PREADY), .PRDATA(PRDATA),
    .TARGET_PORT(TARGET_PORT), .EGRESS_BLOCK_BITS(EGRESS_BLOCK_BITS), .BLOCK_HIT(BLOCK_HIT),
    .MC_GROUP_COUNT(MC_GROUP_COUNT), .ECRC_REGEN_SUPPORTED(ECRC_REGEN_SUPPORTED),
    .NEXT_CAPABILITY_POINTER(NEXT_CAPABILITY_POINTER));

// >>> tb/evmc_tb.sv
`timescale 1ns/100ps
// ====
// bench
module tb;
    import evmc_pkg::*;
    logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, mm = 0, rdy, slv, hit, ecrc, e;
    logic [11:0] pa = 0, nxt;
    logic [31:0] pwd = 0, prd, q;
    logic [3:0] pn = 0, tp = 0;
    logic [15:0] ebb;
    logic [6:0] gc;
    int err_count = 0, check_count = 0;
    always #4 clk = ~clk;
    evmc_regs u_dut (.CORE_CLK(clk), .RESET_N(rst_n), .CORE_CE(1'b1), .PSEL(psel), .PENABLE(pen),
        .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PSTRB(4'hF), .PREADY(rdy), .PRDATA(prd),
        .PSLVERR(slv), .PORT_NUM(pn), .MERGED_MODE(mm), .TARGET_PORT(tp), .EGRESS_BLOCK_BITS(ebb),
        .BLOCK_HIT(hit), .MC_GROUP_COUNT(gc), .ECRC_REGEN_SUPPORTED(ecrc), .NEXT_CAPABILITY_POINTER(nxt));
    task chk(input logic [31:0] g, input logic [31:0] x);
        check_count++;
        if (g !== x) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask : chk
    // waits for pready with no fixed count; watchdog ends a hang
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (rdy !== 1'b1);
        q = prd;
        e = slv;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    task rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(q, x);
    endtask : rd
    task settle;
        repeat (3) @(posedge clk);
    endtask : settle
    task t_reset;
        rd(EVMC_OFS_EGRESS_VEC, 32'h0);
        rd(EVMC_OFS_MC_HEADER, 32'h00010012);
        rd(EVMC_OFS_MC_CAP, 32'h0000801F);
        chk({25'h0, gc}, 32'h20);
    endtask : t_reset
    task t_vector;
        pn <= 4'h3;
        apb(1'b1, EVMC_OFS_EGRESS_CTL, 32'h1);
        apb(1'b1, EVMC_OFS_EGRESS_VEC, 32'hFFFF);
        rd(EVMC_OFS_EGRESS_VEC, 32'hFFF7);
        apb(1'b1, EVMC_OFS_EGRESS_VEC, 32'h0020);
        tp <= 4'h5;
        settle;
        chk({16'h0, ebb}, 32'h0020);
        chk({31'h0, hit}, 32'h1);
        tp <= 4'h4;
        settle;
        chk({31'h0, hit}, 32'h0);
        apb(1'b1, EVMC_OFS_EGRESS_CTL, 32'h0);
        settle;
        chk({16'h0, ebb}, 32'h0);
    endtask : t_vector
    task t_merged;
        pn <= 4'h6;
        mm <= 1'b1;
        apb(1'b1, EVMC_OFS_EGRESS_CTL, 32'h1);
        apb(1'b1, EVMC_OFS_EGRESS_VEC, 32'hFFFF);
        rd(EVMC_OFS_EGRESS_VEC, 32'hFF3F);
        settle;
        chk({16'h0, ebb}, 32'hFF3F);
    endtask : t_merged
    task t_cap;
        apb(1'b1, EVMC_OFS_MC_CAP, 32'hFFFF7FFF);
        rd(EVMC_OFS_MC_CAP, 32'h3F);
        chk({25'h0, gc}, 32'h40);
        apb(1'b1, EVMC_OFS_MC_HEADER, 32'hFFFFFFFF);
        rd(EVMC_OFS_MC_HEADER, 32'hFFF10012);
        chk({20'h0, nxt}, 32'hFFF);
        apb(1'b1, EVMC_OFS_EGRESS_CTL, 32'h2);
        apb(1'b1, EVMC_OFS_MC_CAP, 32'h801F);
        rd(EVMC_OFS_MC_CAP, 32'h3F);
        apb(1'b1, 12'h3FC, 32'hFFFFFFFF);
        chk({31'h0, e}, 32'h1);
    endtask : t_cap
    task stop_test;
        $display("errors %0d checks %0d", err_count, check_count);
        if (err_count == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_reset;
        t_vector;
        t_merged;
        t_cap;
        stop_test;
    end
    initial begin
        #50000;
        err_count++;
        stop_test;
    end
endmodule : tb
